// ### rtl/p5s_top.sv
// port 5 strap decode, pin direction control and apb status
`timescale 1ns/1ns
`default_nettype none
`include "p5s_defines.svh"
module p5s_top
   import p5s_pkg::*;
#(
   parameter int CLK_HALF = 1
)
(
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   input  wire logic        WARM_RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [19:0] STRAP_IN,
   input  wire logic [17:0] STRAP_FUNC,
   output logic      [17:0] STRAP_OUT,
   output logic      [17:0] STRAP_OE,
   input  wire logic [3:0]  SW_PIN_IN,
   input  wire logic [1:0]  SW_STAT_FUNC,
   output logic      [3:0]  SW_PIN_OUT,
   output logic      [3:0]  SW_PIN_OE,
   output logic      [1:0]  PHY5_CLK_OUT,
   output logic      [1:0]  PHY5_CLK_OE,
   output logic      [1:0]  SW_MODE,
   output logic             PHY5_EN,
   output logic             CORE_CLK_EXT,
   output logic      [8:0]  GLOBAL_OPTS,
   output logic      [7:0]  PORT3_CTRL,
   output logic      [7:0]  PORT4_CTRL,
   output logic      [7:0]  POWER_CTRL
);

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      p5s_st_t     st;
      logic [1:0]  cnt;
      logic [19:0] straps;
      logic        rmii;
      logic        resmp;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        txc_prev;
      logic [15:0] edge_cnt;
      logic [17:0] strap_out;
      logic [17:0] strap_oe;
      logic [3:0]  sw_oe;
      logic [1:0]  sw_stat;
      logic [1:0]  phy5_oe;
      p5s_sw_t     sw_mode;
      logic        phy5_en;
      logic        clk_ext;
      logic [8:0]  opts;
      logic [7:0]  p3;
      logic [7:0]  p4;
      logic [7:0]  pwr;
   } p5s_state_t;

   p5s_state_t s_r;
   p5s_state_t s_nxt;
   logic [24:0] pin_q;
   logic        clk_div;
   logic        run;
   logic        sw_phy;
   logic [2:0]  code;

   // pins arrive asynchronously: strap, switch side and warm reset
   p5s_sync #(.W(25)) u_sync
   (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .d      ({WARM_RST_N, SW_PIN_IN, STRAP_IN}),
      .q      (pin_q)
   );

   // link-side clock; runs whenever the straps are latched, in every mode
   p5s_clkdiv #(.HALF(CLK_HALF)) u_div
   (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .en     (run),
      .clk_o  (clk_div)
   );

   ////////////////////////////////////////////////////////////////////
   // mode code is {interface enable, cfg mid, cfg low}
   assign run    = (s_r.st == P5S_RUN);
   assign code   = {s_r.straps[`P5S_S_IFEN], s_r.straps[`P5S_S_CFGMID],
                    s_r.straps[`P5S_S_CFGLO]};
   assign sw_phy = (s_r.sw_mode == P5S_SW_PHY_MII) ||
                   (s_r.sw_mode == P5S_SW_PHY_SNI);

   function automatic logic [31:0] rd_word(input p5s_state_t st,
                                           input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0;
      if (a == `P5S_A_STRAP)
         w = {12'h0, st.straps};
      else if (a == `P5S_A_CFG)
         w = {31'h0, st.rmii};
      else if (a == `P5S_A_MODE)
         w = {27'h0, st.st == P5S_RUN, st.clk_ext, st.phy5_en, st.sw_mode};
      else if (a == `P5S_A_PORTS)
         w = {8'h0, st.pwr, st.p4, st.p3};
      else if (a == `P5S_A_LINK)
         w = {14'h0, pin_q[23:22], st.edge_cnt};
      else if (a == `P5S_A_OPTS)
         w = {23'h0, st.opts};
      return w;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a == `P5S_A_STRAP) || (a == `P5S_A_CFG) ||
             (a == `P5S_A_MODE) || (a == `P5S_A_PORTS) ||
             (a == `P5S_A_LINK) || (a == `P5S_A_OPTS);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      s_nxt = s_r;
      // sampling window: pins stay undriven until straps are latched
      if (s_r.st == P5S_HOLD)
      begin
         if (s_r.cnt == `P5S_SMP_CYC)
         begin
            s_nxt.straps = pin_q[19:0];
            s_nxt.st     = P5S_RUN;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 2'h1;
         end
      end
      // warm reset or software resample reopens the window
      if (!pin_q[24] || s_r.resmp)
      begin
         s_nxt.st  = P5S_HOLD;
         s_nxt.cnt = 2'h0;
      end
      s_nxt.resmp = 1'b0;

      // apb: one wait state, write commits at the pready edge
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (PSEL && PENABLE && !s_r.pready)
      begin
         s_nxt.pready  = 1'b1;
         s_nxt.prdata  = PWRITE ? 32'h0 : rd_word(s_r, PADDR);
         s_nxt.pslverr = !addr_ok(PADDR);
      end
      if (PSEL && PENABLE && s_r.pready && PWRITE && PADDR == `P5S_A_CFG)
      begin
         s_nxt.rmii  = PWDATA[`P5S_CFG_RMII];
         s_nxt.resmp = PWDATA[`P5S_CFG_RESMP];
      end

      // link clock edges, counted while the switch clock pin is input
      s_nxt.txc_prev = pin_q[20];
      if (pin_q[20] && !s_r.txc_prev && !s_r.sw_oe[0])
         s_nxt.edge_cnt = s_r.edge_cnt + 16'h1;

      // mode decode; code 100 lands on switch off by its low bits
      s_nxt.sw_mode = p5s_sw_t'(code[1:0]);
      s_nxt.phy5_en = run && code[2] && (code[1:0] != 2'h0);
      s_nxt.clk_ext = s_r.rmii && !s_r.straps[`P5S_S_RMCLK];

      // pin directions: nothing driven before the latch
      s_nxt.strap_out    = STRAP_FUNC;
      s_nxt.strap_oe     = 18'h0;
      s_nxt.sw_oe        = 4'h0;
      s_nxt.phy5_oe      = 2'h0;
      s_nxt.sw_stat      = SW_STAT_FUNC;
      if (run)
      begin
         s_nxt.strap_oe[6:0]   = {7{s_r.phy5_en}};
         s_nxt.strap_oe[9:7]   = {3{s_r.sw_mode != P5S_SW_OFF}};
         s_nxt.strap_oe[17:10] = 8'hff;
         s_nxt.sw_oe[0]  = sw_phy && !s_r.rmii;
         s_nxt.sw_oe[1]  = (sw_phy && !s_r.rmii) || (s_r.rmii &&
                           !s_r.clk_ext && s_r.sw_mode != P5S_SW_OFF);
         s_nxt.sw_oe[3:2] = {2{sw_phy && !s_r.rmii}};
         s_nxt.phy5_oe[1] = s_r.phy5_en;
         s_nxt.phy5_oe[0] = s_r.phy5_en && !s_r.rmii;
      end

      // global options from the phy5 and switch receive straps
      s_nxt.opts[`P5S_O_FLOW]    = !s_r.straps[`P5S_S_RXB3];
      s_nxt.opts[`P5S_O_BP]      = s_r.straps[`P5S_S_RXB2];
      s_nxt.opts[`P5S_O_KEEPCOL] = s_r.straps[`P5S_S_RXB1];
      s_nxt.opts[`P5S_O_BACKOFF] = s_r.straps[`P5S_S_RXB0];
      s_nxt.opts[`P5S_O_PKT1536] = s_r.straps[`P5S_S_RXERR];
      s_nxt.opts[`P5S_O_SWFC]    = s_r.straps[`P5S_S_SWB3];
      s_nxt.opts[`P5S_O_SWHALF]  = s_r.straps[`P5S_S_SWB2];
      s_nxt.opts[`P5S_O_LED1]    = s_r.straps[`P5S_S_SWB0];
      s_nxt.opts[`P5S_O_AGING]   = s_r.straps[`P5S_S_AGING];

      // port control defaults; other bits stay zero
      s_nxt.p4 = 8'h0;
      s_nxt.p4[`P5S_PC_AN]    = s_r.straps[`P5S_S_P4AN];
      s_nxt.p4[`P5S_PC_FDUP]  = s_r.straps[`P5S_S_CRS];
      s_nxt.p4[`P5S_PC_FFLOW] = s_r.straps[`P5S_S_COL];
      s_nxt.p3 = 8'h0;
      s_nxt.p3[`P5S_PC_AN]    = s_r.straps[`P5S_S_P3AN];
      s_nxt.p3[`P5S_PC_FFLOW] = !s_r.straps[`P5S_S_P3FLOW];
      s_nxt.p3[`P5S_PC_FDUP]  = !s_r.straps[`P5S_S_P3DUP];
      s_nxt.pwr = 8'h0;
      s_nxt.pwr[`P5S_PWR_LSB+:2] = s_r.straps[`P5S_S_EDET] ?
                                   `P5S_PWR_NORM : `P5S_PWR_ENERGY_DETECT_POWERDOWN;
   end

   ////////////////////////////////////////////////////////////////////
   // state register; straps reset to zero and are filled when the sampling window closes
   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // outputs all come from flops
   assign PRDATA       = s_r.prdata;
   assign PREADY       = s_r.pready;
   assign PSLVERR      = s_r.pslverr;
   assign STRAP_OUT    = s_r.strap_out;
   assign STRAP_OE     = s_r.strap_oe;
   assign SW_PIN_OUT   = {s_r.sw_stat, clk_div, clk_div};
   assign SW_PIN_OE    = s_r.sw_oe;
   assign PHY5_CLK_OUT = {clk_div, clk_div};
   assign PHY5_CLK_OE  = s_r.phy5_oe;
   assign SW_MODE      = s_r.sw_mode;
   assign PHY5_EN      = s_r.phy5_en;
   assign CORE_CLK_EXT = s_r.clk_ext;
   assign GLOBAL_OPTS  = s_r.opts;
   assign PORT3_CTRL   = s_r.p3;
   assign PORT4_CTRL   = s_r.p4;
   assign POWER_CTRL   = s_r.pwr;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_answer;
      PSEL && PENABLE && PREADY;
   endsequence

   property p_oe_hold;
      s_r.st == P5S_HOLD |=> STRAP_OE == 18'h0;
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("strap pin driven in hold");

   property p_latch_stable;
      run && $past(run) |-> $stable(s_r.straps);
   endproperty
   a_latch_stable: assert property (p_latch_stable) else $error("straps moved");

   property p_phy5_off;
      !PHY5_EN |=> STRAP_OE[6:0] == 7'h0 && PHY5_CLK_OE == 2'h0;
   endproperty
   a_phy5_off: assert property (p_phy5_off) else $error("phy5 pins driven");

   property p_code100;
      run && code == 3'h4 |=> SW_MODE == P5S_SW_OFF && !PHY5_EN;
   endproperty
   a_code100: assert property (p_code100) else $error("code 100 not off");

   property p_flow;
      run ##1 run |-> GLOBAL_OPTS[`P5S_O_FLOW] == !$past(s_r.straps[`P5S_S_RXB3]);
   endproperty
   a_flow: assert property (p_flow) else $error("flow option wrong");

   property p_p3dup;
      run ##1 run |-> PORT3_CTRL[`P5S_PC_FDUP] == !$past(s_r.straps[`P5S_S_P3DUP]);
   endproperty
   a_p3dup: assert property (p_p3dup) else $error("port3 duplex wrong");

   property p_mac_in;
      SW_MODE == P5S_SW_MAC_MII && !s_r.rmii |=> SW_PIN_OE == 4'h0;
   endproperty
   a_mac_in: assert property (p_mac_in) else $error("mac mode pin driven");

   property p_warm;
      !pin_q[24] |=> s_r.st == P5S_HOLD ##1 STRAP_OE == 18'h0;
   endproperty
   a_warm: assert property (p_warm) else $error("warm reset ignored");

   property p_apb;
      s_setup ##1 (PSEL && PENABLE) |-> ##1 PREADY;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");

   property p_apb_once;
      s_answer |=> !PREADY;
   endproperty
   a_apb_once: assert property (p_apb_once) else $error("pready held");
endmodule
`default_nettype wire

// ### rtl/p5s_defines.svh
// strap indices, register offsets, field positions and timing counts
`ifndef P5S_DEFINES_SVH
`define P5S_DEFINES_SVH
// strap vector positions
`define P5S_S_RXB0    0
`define P5S_S_RXB1    1
`define P5S_S_RXB2    2
`define P5S_S_RXB3    3
`define P5S_S_RXERR   4
`define P5S_S_CRS     5
`define P5S_S_COL     6
`define P5S_S_SWB0    7
`define P5S_S_SWB2    8
`define P5S_S_SWB3    9
`define P5S_S_AGING   10
`define P5S_S_IFEN    11
`define P5S_S_P4AN    12
`define P5S_S_EDET    13
`define P5S_S_RMCLK   14
`define P5S_S_P3AN    15
`define P5S_S_P3FLOW  16
`define P5S_S_P3DUP   17
`define P5S_S_CFGLO   18
`define P5S_S_CFGMID  19
// global option bits
`define P5S_O_FLOW    0
`define P5S_O_BP      1
`define P5S_O_KEEPCOL 2
`define P5S_O_BACKOFF 3
`define P5S_O_PKT1536 4
`define P5S_O_SWFC    5
`define P5S_O_SWHALF  6
`define P5S_O_LED1    7
`define P5S_O_AGING   8
// port control bits
`define P5S_PC_AN     7
`define P5S_PC_FDUP   5
`define P5S_PC_FFLOW  4
`define P5S_PWR_LSB   3
`define P5S_PWR_ENERGY_DETECT_POWERDOWN  2'h1
`define P5S_PWR_NORM  2'h0
// register byte offsets and cfg register bit positions
`define P5S_A_STRAP   8'h00
`define P5S_A_CFG     8'h04
`define P5S_A_MODE    8'h08
`define P5S_A_PORTS   8'h0c
`define P5S_A_LINK    8'h10
`define P5S_A_OPTS    8'h14
`define P5S_CFG_RMII  0
`define P5S_CFG_RESMP 1
// sampling delay after reset release, in REF_CLK cycles;
// long enough for the oe drop to pass both sync stages
`define P5S_SMP_CYC   2'h3
`endif

// ### rtl/p5s_pkg.sv
// types shared by the port 5 strap configuration block
package p5s_pkg;
   typedef enum logic {P5S_HOLD, P5S_RUN} p5s_st_t;
   typedef enum logic [1:0] {P5S_SW_OFF, P5S_SW_PHY_MII, P5S_SW_MAC_MII,
                             P5S_SW_PHY_SNI} p5s_sw_t;
endpackage

// ### rtl/p5s_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module p5s_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ### rtl/p5s_clkdiv.sv
// divider that makes the driven link clock from REF_CLK
`timescale 1ns/1ns
`default_nettype none
module p5s_clkdiv
#(
   parameter int HALF = 1
)
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic en,
   output logic      clk_o
);
   localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
   logic [CW-1:0] cnt_r;

   // parked low while disabled so the pin starts clean
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r <= '0;
         clk_o <= 1'b0;
      end
      else if (!en)
      begin
         cnt_r <= '0;
         clk_o <= 1'b0;
      end
      else if (cnt_r == CW'(HALF - 1))
      begin
         cnt_r <= '0;
         clk_o <= ~clk_o;
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### dv/p5s_far_end.sv
// far-end mac model on the switch-side port 5 clock and status pins
`timescale 1ns/1ns
`default_nettype none
module p5s_far_end
(
   input  wire logic        run,
   input  wire logic [3:0]  dev_out,
   input  wire logic [3:0]  dev_oe,
   input  wire logic [1:0]  stat,
   output logic      [3:0]  pin,
   output logic      [15:0] n_edges
);
   logic clk_r;

   ////////////////////////////////////////////////////////////////////////////
   // link clock toggles only inside a burst and rests low between bursts
   initial
   begin
      clk_r = 1'b0;
      n_edges = 16'h0;
      #13;
      forever
      begin
         #400;
         if (run || clk_r)
         begin
            clk_r = ~clk_r;
            n_edges = n_edges + {15'h0, clk_r};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the device owns a pin while it enables it, the far end otherwise
   assign pin[0] = dev_oe[0] ? dev_out[0] : clk_r;
   assign pin[1] = dev_oe[1] ? dev_out[1] : clk_r;
   assign pin[2] = dev_oe[2] ? dev_out[2] : stat[0];
   assign pin[3] = dev_oe[3] ? dev_out[3] : stat[1];
endmodule
`default_nettype wire

// ### dv/port5_strap_config_tb_top.sv
// self-checking bench for the port 5 strap decode block
`timescale 1ns/1ns
`default_nettype none
module port5_strap_config_tb_top;
   logic        ref_clk, arst_n, warm_rst_n, psel, penable, pwrite;
   logic        pready, pslverr, phy5_en, core_clk_ext, run, err;
   logic [7:0]  paddr, port3_ctrl, port4_ctrl, power_ctrl;
   logic [31:0] pwdata, prdata, rd, r0;
   logic [19:0] s_r, s;
   logic [17:0] strap_func, strap_out, strap_oe, sf_d;
   logic [3:0]  sw_pin_in, sw_pin_out, sw_pin_oe;
   logic [1:0]  sw_stat_func, phy5_clk_out, phy5_clk_oe, sw_mode, ss_d;
   logic [8:0]  global_opts;
   logic [15:0] fe_edges, e0;
   int          n_mismatch, total_checks;

   ////////////////////////////////////////////////////////////////////////////
   // undriven strap pins fall back to their pull level
   wire [19:0] strap_in = {s_r[19:18], (strap_oe & strap_out) | (~strap_oe & s_r[17:0])};

   p5s_top DUT (.REF_CLK(ref_clk), .ARST_N(arst_n), .WARM_RST_N(warm_rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .STRAP_IN(strap_in), .STRAP_FUNC(strap_func),
      .STRAP_OUT(strap_out), .STRAP_OE(strap_oe), .SW_PIN_IN(sw_pin_in),
      .SW_STAT_FUNC(sw_stat_func), .SW_PIN_OUT(sw_pin_out), .SW_PIN_OE(sw_pin_oe),
      .PHY5_CLK_OUT(phy5_clk_out), .PHY5_CLK_OE(phy5_clk_oe), .SW_MODE(sw_mode),
      .PHY5_EN(phy5_en), .CORE_CLK_EXT(core_clk_ext), .GLOBAL_OPTS(global_opts),
      .PORT3_CTRL(port3_ctrl), .PORT4_CTRL(port4_ctrl), .POWER_CTRL(power_ctrl));

   p5s_far_end u_far (.run(run), .dev_out(sw_pin_out), .dev_oe(sw_pin_oe),
      .stat(sw_stat_func), .pin(sw_pin_in), .n_edges(fe_edges));

   always #50 ref_clk = ~ref_clk;

   // output-phase pin data changes every cycle, so a stuck latch shows
   always @(posedge ref_clk)
   begin
      strap_func <= 18'($urandom);
      sw_stat_func <= 2'($urandom);
      sf_d <= strap_func;
      ss_d <= sw_stat_func;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, waiting a bounded time for the slave
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-raises psel in this step
      @(posedge ref_clk);
      if (i >= 20)
      begin
         n_mismatch++;
         final_report();
      end
   endtask

   function automatic logic [8:0] exp_opts(input logic [19:0] v);
      return {v[10], v[7], v[8], v[9], v[4], v[0], v[1], v[2], ~v[3]};
   endfunction

   // warm reset with new strap levels; pins must float meanwhile
   task automatic restrap(input logic [19:0] v);
      s_r <= v;
      warm_rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk(strap_oe, 0);
      warm_rst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
   endtask

   // full decode of latched straps in the mii variant
   task automatic check_cfg(input logic [19:0] v);
      logic [2:0] c;
      logic [1:0] m;
      logic       en;
      c = {v[11], v[19], v[18]};
      m = (c == 3'h4) ? 2'h0 : c[1:0];
      en = v[11] & (v[19] | v[18]);
      chk(sw_mode, m);
      chk(phy5_en, en);
      chk(phy5_clk_oe, {2{en}});
      chk(strap_oe, {8'hff, {3{m != 2'h0}}, {7{en}}});
      chk(sw_pin_oe, (m == 2'h1 || m == 2'h3) ? 4'hf : 4'h0);
      chk(global_opts, exp_opts(v));
      chk(port4_ctrl, {v[12], 1'b0, v[5], v[6], 4'h0});
      chk(port3_ctrl, {v[15], 1'b0, ~v[17], ~v[16], 4'h0});
      chk(power_ctrl, {3'h0, 1'b0, ~v[13], 3'h0});
      chk(strap_out, sf_d);
      chk(sw_pin_out[3:2], ss_d);
      apb(1'b0, 8'h08, 0);
      chk(rd, {27'h0, 1'b1, 1'b0, en, m});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      warm_rst_n = 1'b1;
      {psel, penable, pwrite, run} = 4'h0;
      paddr = 8'h0;
      pwdata = 0;
      strap_func = 18'h0;
      sw_stat_func = 2'h0;
      s_r = 20'h3fc00;
      n_mismatch = 0;
      total_checks = 0;
      void'($urandom(27));
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check_cfg(20'h3fc00);
      // every port 5 code, other straps random
      for (int k = 0; k < 8; k++)
      begin
         s = 20'($urandom);
         {s[11], s[19], s[18]} = 3'(k);
         restrap(s);
         check_cfg(s);
      end
      // pins now toggle as outputs; latched setup must not move
      s_r <= ~s;
      repeat (8) @(posedge ref_clk);
      check_cfg(s);
      s_r <= s;
      // read-only write ignored, unmapped address refused
      apb(1'b1, 8'h14, 32'hffffffff);
      apb(1'b0, 8'h14, 0);
      chk(rd, {23'h0, exp_opts(s)});
      apb(1'b0, 8'h18, 0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // mac mode: far end clocks the switch tx clock pin
      s = 20'($urandom);
      {s[11], s[19], s[18]} = 3'h2;
      restrap(s);
      apb(1'b0, 8'h10, 0);
      r0 = rd;
      e0 = fe_edges;
      run <= 1'b1;
      repeat (300) @(posedge ref_clk);
      run <= 1'b0;
      repeat (20) @(posedge ref_clk);
      apb(1'b0, 8'h10, 0);
      chk(rd[15:0] - r0[15:0], fe_edges - e0);
      // rmii variant: clock strap picks crystal or external core clock
      for (int t = 0; t < 2; t++)
      begin
         s = 20'($urandom);
         {s[11], s[19], s[18]} = 3'h5;
         s[14] = t[0];
         restrap(s);
         apb(1'b1, 8'h04, 32'h3);
         repeat (10) @(posedge ref_clk);
         chk(core_clk_ext, {31'h0, ~s[14]});
         chk(sw_pin_oe[1], s[14]);
         chk(phy5_clk_oe, 2'h2);
         // default divider toggles the driven clocks on every edge
         r0[1:0] = phy5_clk_out;
         @(posedge ref_clk);
         chk({30'h0, phy5_clk_out ^ r0[1:0]}, 32'h3);
      end
      final_report();
   end
endmodule
`default_nettype wire
